// *** verilog/etimer_map.svh ***
// register offsets, field positions and reset values of the enhanced timer
// assumes an apb slave with 32-bit data, one aligned word per register
`ifndef ETIMER_MAP_SVH
`define ETIMER_MAP_SVH

`define ADDR_CTRL_ONE 12'h000
`define ADDR_CTRL_TWO 12'h004
`define ADDR_CNT_LO 12'h008
`define ADDR_CNT_HI 12'h00c
`define ADDR_CMPA_LO 12'h010
`define ADDR_CMPA_HI 12'h014
`define ADDR_CMPB_LO 12'h018
`define ADDR_CMPB_HI 12'h01c
`define ADDR_FLAGS 12'h020

// control_reg_one fields
`define C1_RUN 0
`define C1_CLEAR_SEL 1
`define C1_PSEL_LO 2
`define C1_A_INIT 5
`define C1_A_ACT_LO 6
`define C1_A_MODE_LO 8
// control_reg_two fields
`define C2_ALIGN_LO 0
`define C2_B_INVERT 2
`define C2_B_INIT 3
`define C2_B_ACT_LO 4
`define C2_B_MODE_LO 6
// flag register fields, write one to clear
`define FL_A 0
`define FL_B 1
`define FL_P 2

`define CTRL_ONE_RESET 10'h000
`define CTRL_TWO_RESET 8'h00
`define PERIOD_STEP 128

`endif

// *** verilog/etimer_pkg.sv ***
// types shared by the enhanced timer design
// assumes nothing beyond a systemverilog compiler
package etimer_pkg;
  typedef enum logic [1:0] {
    MODE_COMPARE = 2'h0,
    MODE_CAPTURE = 2'h1,
    MODE_PWM = 2'h2,
    MODE_TIMER = 2'h3
  } mode_t;
  typedef enum logic [1:0] {
    ACT_NONE = 2'h0,
    ACT_LOW = 2'h1,
    ACT_HIGH = 2'h2,
    ACT_TOGGLE = 2'h3
  } pin_action_t;
endpackage : etimer_pkg

// *** verilog/enhanced_timer.sv ***
// enhanced timer compare core with apb register access
// assumes one 250 MHz clock pclk and an apb master on the same clock
//
// Summary of operation
// - b invert bit inverts all b pins
// - b invert ignored in timer/counter mode
// - align field gates matches to up/down/both; count is always up
// - counter readable as low and high byte
// - channel a compare value, two bytes
// - channel b compare value, two bytes
// - unused high bits read zero, reset zero
// - four modes chosen by per-channel bits
// - clear select low: period or overflow clears
// - clear select high: match a clears
// - only a/b matches move the pins
// - pin action high, low or toggle
// - run rising edge loads initial levels
// - action zero leaves pin unchanged
// - timer mode counts and flags, no pins
// - timer mode releases the pins
// - initial level holds before first match
// - period value is select times 128
//
// The APB slave port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`include "etimer_map.svh"

module enhanced_timer
  import etimer_pkg::*;
#(
  parameter int CNT_W = 10,
  parameter int B_PINS = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic out_pin_a,
  output logic out_pin_a_oe,
  output logic [B_PINS-1:0] out_pin_b,
  output logic [B_PINS-1:0] out_pin_b_oe,
  output logic match_a_flag,
  output logic match_b_flag,
  output logic period_match_flag
);

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  logic [9:0] control_reg_one_q;
  logic [7:0] control_reg_two_q;
  logic [CNT_W-1:0] compare_a_value_q;
  logic [CNT_W-1:0] compare_b_value_q;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0] flags_q;
  logic run_prev_q;
  logic pin_a_q;
  logic pin_b_q;
  logic up_q;

  logic wr_en;
  logic rd_en;
  logic counter_run;
  logic clear_select;
  logic [2:0] period_select;
  mode_t mode_a;
  mode_t mode_b;
  pin_action_t act_a;
  pin_action_t act_b;
  logic [1:0] pwm_align_select;
  logic output_b_invert;
  logic timer_mode;
  logic run_rise;
  logic hit_a;
  logic hit_b;
  logic hit_p;
  logic overflow;
  logic clear_cnt;
  logic dir_ok;
  logic [CNT_W-1:0] period_value;

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~pwrite;
  // single-cycle access phase, no wait states
  assign pready = 1'b1;

  assign counter_run = control_reg_one_q[`C1_RUN];
  assign clear_select = control_reg_one_q[`C1_CLEAR_SEL];
  assign period_select = control_reg_one_q[`C1_PSEL_LO +: 3];
  assign mode_a = mode_t'(control_reg_one_q[`C1_A_MODE_LO +: 2]);
  assign mode_b = mode_t'(control_reg_two_q[`C2_B_MODE_LO +: 2]);
  assign act_a = pin_action_t'(control_reg_one_q[`C1_A_ACT_LO +: 2]);
  assign act_b = pin_action_t'(control_reg_two_q[`C2_B_ACT_LO +: 2]);
  assign pwm_align_select = control_reg_two_q[`C2_ALIGN_LO +: 2];
  assign output_b_invert = control_reg_two_q[`C2_B_INVERT];

  // timer mode needs both channels at 11
  assign timer_mode = (mode_a == MODE_TIMER) && (mode_b == MODE_TIMER);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_one_q <= `CTRL_ONE_RESET;
    end else if (wr_en && paddr == `ADDR_CTRL_ONE) begin
      control_reg_one_q <= pwdata[9:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_two_q <= `CTRL_TWO_RESET;
    end else if (wr_en && paddr == `ADDR_CTRL_TWO) begin
      control_reg_two_q <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      compare_a_value_q <= '0;
      compare_b_value_q <= '0;
    end else if (wr_en) begin
      if (paddr == `ADDR_CMPA_LO) begin
        compare_a_value_q[7:0] <= pwdata[7:0];
      end else if (paddr == `ADDR_CMPA_HI) begin
        compare_a_value_q[CNT_W-1:8] <= pwdata[CNT_W-9:0];
      end else if (paddr == `ADDR_CMPB_LO) begin
        compare_b_value_q[7:0] <= pwdata[7:0];
      end else if (paddr == `ADDR_CMPB_HI) begin
        compare_b_value_q[CNT_W-1:8] <= pwdata[CNT_W-9:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  // counter split into two bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (rd_en && !penable) begin
      pslverr <= 1'b0;
      if (paddr == `ADDR_CTRL_ONE) begin
        prdata <= {22'h0, control_reg_one_q};
      end else if (paddr == `ADDR_CTRL_TWO) begin
        prdata <= {24'h0, control_reg_two_q};
      end else if (paddr == `ADDR_CNT_LO) begin
        prdata <= {24'h0, cnt_q[7:0]};
      end else if (paddr == `ADDR_CNT_HI) begin
        prdata <= {30'h0, cnt_q[9:8]};
      end else if (paddr == `ADDR_CMPA_LO) begin
        prdata <= {24'h0, compare_a_value_q[7:0]};
      end else if (paddr == `ADDR_CMPA_HI) begin
        prdata <= {30'h0, compare_a_value_q[9:8]};
      end else if (paddr == `ADDR_CMPB_LO) begin
        prdata <= {24'h0, compare_b_value_q[7:0]};
      end else if (paddr == `ADDR_CMPB_HI) begin
        prdata <= {30'h0, compare_b_value_q[9:8]};
      end else if (paddr == `ADDR_FLAGS) begin
        prdata <= {29'h0, flags_q};
      end else begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b1;
      end
    end else if (psel && !penable) begin
      prdata <= 32'h0000_0000;
      pslverr <= !(paddr == `ADDR_CTRL_ONE || paddr == `ADDR_CTRL_TWO || paddr == `ADDR_CMPA_LO ||
                   paddr == `ADDR_CMPA_HI || paddr == `ADDR_CMPB_LO || paddr == `ADDR_CMPB_HI ||
                   paddr == `ADDR_FLAGS);
    end
  end

  // ----------------------------------------------------------------
  // counter and comparators
  // ----------------------------------------------------------------
  // period in steps of 128, zero means overflow
  assign period_value = CNT_W'(period_select * `PERIOD_STEP);
  assign overflow = (cnt_q == {CNT_W{1'b1}});
  assign run_rise = counter_run & ~run_prev_q;

  // centre modes match only on chosen direction
  always_comb begin
    case (pwm_align_select)
      2'h1: dir_ok = up_q;
      2'h2: dir_ok = ~up_q;
      default: dir_ok = 1'b1;
    endcase
  end

  assign hit_a = counter_run && (cnt_q == compare_a_value_q) && dir_ok;
  assign hit_b = counter_run && (cnt_q == compare_b_value_q) && dir_ok;
  // no period match with clear select high
  assign hit_p = counter_run && !clear_select && (period_select != 3'h0) && (cnt_q == period_value);

  // clear select low: period or overflow clears the counter; high: match a clears it
  assign clear_cnt = clear_select ? hit_a : (hit_p || (period_select == 3'h0 && overflow));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_prev_q <= 1'b0;
    end else begin
      run_prev_q <= counter_run;
    end
  end

  // timer mode counts the same way
  // every align setting counts up only; up_q is never cleared, so nothing turns at the ends
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      up_q <= 1'b1;
    end else if (counter_run) begin
      if (clear_cnt) begin
        cnt_q <= '0;
        up_q <= 1'b1;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

  // flags stick, write one clears, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_q <= 3'h0;
    end else begin
      flags_q <= (flags_q & ~((wr_en && paddr == `ADDR_FLAGS) ? pwdata[2:0] : 3'h0)) |
                 {hit_p, hit_b, hit_a};
    end
  end

  assign match_a_flag = flags_q[`FL_A];
  assign match_b_flag = flags_q[`FL_B];
  assign period_match_flag = flags_q[`FL_P];

  // ----------------------------------------------------------------
  // output pins
  // ----------------------------------------------------------------
  function automatic logic next_pin(input pin_action_t act, input logic cur);
    case (act)
      ACT_LOW: next_pin = 1'b0;
      ACT_HIGH: next_pin = 1'b1;
      ACT_TOGGLE: next_pin = ~cur;
      default: next_pin = cur;
    endcase
  endfunction : next_pin

  // run rising edge loads initial levels
  // only a and b matches move pins
  // action field picks high, low, toggle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
    end else if (run_rise) begin
      pin_a_q <= control_reg_one_q[`C1_A_INIT];
      pin_b_q <= control_reg_two_q[`C2_B_INIT];
    end else begin
      if (hit_a) begin
        pin_a_q <= next_pin(act_a, pin_a_q);
      end
      if (hit_b) begin
        pin_b_q <= next_pin(act_b, pin_b_q);
      end
    end
  end

  // invert has no meaning once released
  assign out_pin_a = timer_mode ? 1'b0 : pin_a_q;
  assign out_pin_b = timer_mode ? '0 : {B_PINS{pin_b_q ^ output_b_invert}};
  assign out_pin_a_oe = ~timer_mode;
  assign out_pin_b_oe = {B_PINS{~timer_mode}};

endmodule : enhanced_timer

// *** testbench/enhanced_timer_assertions.sv ***
// checker on the enhanced timer ports
// assumes the design's register map and one pclk domain
`timescale 1ns/1ns
module enhanced_timer_chk #(
  parameter int B_PINS = 3
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic out_pin_a,
  input wire logic out_pin_a_oe,
  input wire logic [B_PINS-1:0] out_pin_b,
  input wire logic [B_PINS-1:0] out_pin_b_oe,
  input wire logic match_a_flag,
  input wire logic match_b_flag,
  input wire logic period_match_flag
);
  // --------
  // helpers
  // --------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic su = psel && !penable;
  wire logic fw = psel && penable && pwrite && paddr == 12'h020;
  wire logic cw = psel && penable && pwrite && paddr[11:3] == 9'h0;
  // -----------
  // properties
  // -----------
  a_b_pins_same: assert property (out_pin_b == {B_PINS{out_pin_b[0]}})
    else $error("b pins differ");
  a_oe_pair: assert property (out_pin_b_oe == {B_PINS{out_pin_a_oe}})
    else $error("pin enables differ");
  a_released_low: assert property (!out_pin_a_oe |-> !out_pin_a && out_pin_b == '0)
    else $error("released pins not low");
  a_oe_cause: assert property ($changed(out_pin_a_oe) |-> $past(cw))
    else $error("enable moved without control write");
  a_flag_clear: assert property ($fell(match_a_flag) |-> $past(fw && pwdata[0]))
    else $error("match a flag fell on its own");
  a_p_flag_hold: assert property (period_match_flag && !(fw && pwdata[2]) |=> period_match_flag)
    else $error("period flag dropped");
  a_cnt_refused: assert property (su && pwrite && (paddr == 12'h008 || paddr == 12'h00c) |=> pslverr)
    else $error("counter write accepted");
  a_hi_zero: assert property (su && !pwrite && (paddr == 12'h00c || paddr == 12'h014 || paddr == 12'h01c)
    |=> prdata[31:2] == '0)
    else $error("high byte upper bits set");
endmodule : enhanced_timer_chk

bind enhanced_timer enhanced_timer_chk #(.B_PINS(B_PINS)) i_enhanced_timer_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .out_pin_a(out_pin_a), .out_pin_a_oe(out_pin_a_oe), .out_pin_b(out_pin_b),
  .out_pin_b_oe(out_pin_b_oe), .match_a_flag(match_a_flag), .match_b_flag(match_b_flag),
  .period_match_flag(period_match_flag));

// *** testbench/enhanced_timer_tb.sv ***
// self-checking bench for the enhanced timer over apb
// assumes design and checker compiled first
`timescale 1ns/1ns
module enhanced_timer_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rdat, hold;
  logic pready, pslverr, perr, out_pin_a, out_pin_a_oe, match_a_flag, match_b_flag, period_match_flag;
  logic [2:0] out_pin_b, out_pin_b_oe;
  wire logic [2:0] flags = {period_match_flag, match_b_flag, match_a_flag};
  int err_count = 0, samples_checked = 0;
  enhanced_timer #(.CNT_W(10), .B_PINS(3)) i_enhanced_timer (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .out_pin_a(out_pin_a), .out_pin_a_oe(out_pin_a_oe), .out_pin_b(out_pin_b),
    .out_pin_b_oe(out_pin_b_oe), .match_a_flag(match_a_flag), .match_b_flag(match_b_flag),
    .period_match_flag(period_match_flag));
  // ------
  // tasks
  // ------
  task conclude;
    $display("mismatches %0d, checks %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  task cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : cmp
  // holds the request until pready is seen high at an edge
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      err_count++;
      conclude();
    end
    rdat = prdata;
    perr = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask : xfer
  task rd(input logic [11:0] a, input logic [31:0] exp);
    xfer(0, a, 0);
    cmp(rdat, exp);
  endtask : rd
  task waitf(input int k, input int lim);
    int n;
    n = 0;
    while (flags[k] !== 1'b1 && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (flags[k] !== 1'b1) begin
      err_count++;
      conclude();
    end
  endtask : waitf
  // ---------
  // sequence
  // ---------
  initial begin
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++) rd(12'(4 * i), 0);
    cmp(out_pin_a_oe, 1);
    xfer(1, 12'h008, 32'h3ff);
    cmp(perr, 1);
    rd(12'h008, 0);
    for (int i = 0; i < 4; i++) begin
      xfer(1, 12'(12'h010 + 4 * i), 32'hffffffff);
      rd(12'(12'h010 + 4 * i), (i % 2) ? 32'h3 : 32'hff);
    end
    xfer(1, 12'h010, 32'ha);
    xfer(1, 12'h014, 32'h0);
    xfer(1, 12'h018, 32'h5);
    xfer(1, 12'h01c, 32'h0);
    // b inverted, b starts high, b action low; a toggles and clears the counter
    xfer(1, 12'h004, 32'h1c);
    xfer(1, 12'h000, 32'he3);
    @(posedge pclk);
    cmp(out_pin_a, 1);
    cmp(out_pin_b, 0);
    waitf(0, 100);
    cmp(out_pin_a, 0);
    cmp({match_b_flag, out_pin_b}, 4'hf);
    xfer(1, 12'h020, 32'h1);
    waitf(0, 100);
    cmp(out_pin_a, 1);
    cmp(period_match_flag, 0);
    xfer(1, 12'h000, 32'h0);
    xfer(0, 12'h008, 0);
    hold = rdat;
    rd(12'h008, hold);
    rd(12'h00c, 0);
    xfer(1, 12'h020, 32'h7);
    cmp(flags, 0);
    // period select one, b action none, a action high
    xfer(1, 12'h004, 32'h0c);
    xfer(1, 12'h000, 32'h85);
    repeat (100) @(posedge pclk);
    cmp(period_match_flag, 0);
    waitf(2, 40);
    cmp({match_a_flag, out_pin_a}, 2'h3);
    cmp({match_b_flag, out_pin_b}, 4'h8);
    xfer(0, 12'h008, 0);
    cmp(32'(rdat < 20), 1);
    // timer mode: both channels' mode bits set
    xfer(1, 12'h004, 32'hcc);
    xfer(1, 12'h000, 32'h385);
    cmp({out_pin_a_oe, out_pin_b_oe, out_pin_a, out_pin_b}, 0);
    xfer(1, 12'h020, 32'h7);
    waitf(1, 300);
    cmp({out_pin_a, out_pin_b}, 0);
    // align down-count only: this counter never counts down, so a and b stay quiet
    xfer(1, 12'h004, 32'hce);
    xfer(1, 12'h020, 32'h7);
    repeat (300) @(posedge pclk);
    cmp({30'h0, flags[1:0]}, 0);
    xfer(0, 12'h030, 0);
    cmp(perr, 1);
    cmp(rdat, 0);
    conclude();
  end
endmodule : enhanced_timer_tb
